// ### logic/mag_guard_cfg.svh
// Constants of the mode based memory access guard: register offsets, map and reset values.
// Assumes a 24-bit physical address space and an 8-bit special function register space.
`ifndef MAG_GUARD_CFG_SVH
`define MAG_GUARD_CFG_SVH
`define MAG_SEG_MAX 7'h40
`define MAG_REG_MODE 8'h00
`define MAG_REG_TBL_PTR 8'h04
`define MAG_REG_TBL_CNT 8'h08
`define MAG_REG_CTRL 8'h0C
`define MAG_REG_FW_LO 8'h10
`define MAG_REG_FW_HI 8'h14
`define MAG_REG_XB_LO 8'h18
`define MAG_REG_XB_HI 8'h1C
`define MAG_REG_XS_LO 8'h20
`define MAG_REG_XS_HI 8'h24
`define MAG_REG_COPY_MODE 8'h28
`define MAG_REG_IRQ_ST 8'h2C
`define MAG_REG_IRQ_MASK 8'h30
`define MAG_REG_FAULT 8'h34
`define MAG_IRQ_MEM 0
`define MAG_IRQ_SFR 1
`define MAG_IRQ_WALK 2
`define MAG_TROM_LO 24'h000000
`define MAG_TROM_HI 24'h00FFFF
`define MAG_AROM_LO 24'h010000
`define MAG_AROM_HI 24'h03FFFF
`define MAG_FEE_LO 24'h100000
`define MAG_FEE_HI 24'h10FFFF
`define MAG_AEE_LO 24'h110000
`define MAG_AEE_HI 24'h17FFFF
`define MAG_FRAM_LO 24'h200000
`define MAG_FRAM_HI 24'h2007FF
`define MAG_ARAM_LO 24'h200800
`define MAG_ARAM_HI 24'h20FFFF
`define MAG_COP_BASE 24'h20E000
`define MAG_SFR_CPU_HI 8'h1F
`define MAG_SFR_SEG_HI 8'h2F
`define MAG_SFR_SYS_HI 8'h3F
`define MAG_SFR_FWL_HI 8'h4F
`define MAG_SFR_FWI_HI 8'h5F
`define MAG_SFR_TEST_HI 8'h6F
`define MAG_SFR_HW_LO 8'h80
`define MAG_RST_WORD 32'h00000000
`endif

// ### logic/mag_pkg.sv
// Types shared by the access guard and its surroundings.
// Assumes the constants header is compiled alongside.
package mag_pkg;
  typedef enum logic [2:0] {mag_boot, mag_test, mag_firmware, mag_system, mag_user} mag_mode_t;
  typedef enum logic [1:0] {op_read, op_write, op_exec} mag_op_t;
  typedef enum logic [2:0] {grp_cpu, grp_seg, grp_sys, grp_fwl, grp_fwi, grp_test, grp_hw,
                            grp_none} mag_grp_t;
  typedef enum logic [1:0] {walk_idle, walk_req, walk_wait} mag_walk_t;
  typedef struct packed {
    logic [2:0] rights;
    logic [15:0] sfr_perm;
    logic [23:0] first;
    logic [23:0] last;
    logic [23:0] reloc;
  } mag_seg_t;
  typedef struct packed {
    logic valid;
    logic copy;
    mag_op_t op;
    logic [23:0] vaddr;
  } mag_mreq_t;
  typedef struct packed {
    logic valid;
    logic grant;
    logic fault;
    logic [23:0] paddr;
  } mag_mrsp_t;
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } mag_sreq_t;
  typedef struct packed {
    logic valid;
    logic grant;
    logic fault;
    logic user_bank;
  } mag_srsp_t;
  typedef struct packed {
    logic valid;
    logic write;
    logic [12:0] offset;
  } mag_creq_t;
  typedef struct packed {
    logic valid;
    logic write;
    logic [23:0] paddr;
  } mag_crsp_t;
  typedef struct packed {
    mag_mode_t mode;
    mag_mode_t copy_mode;
    logic [23:0] tbl_ptr;
    logic [6:0] tbl_cnt;
    mag_walk_t walk;
    logic [8:0] wd;
    logic [5:0] cur_seg;
    logic [15:0] fw_lo;
    logic [15:0] fw_hi;
    logic [15:0] xb_lo;
    logic [15:0] xb_hi;
    logic [15:0] xs_lo;
    logic [15:0] xs_hi;
    logic [2:0] irq_st;
    logic [2:0] irq_mask;
    logic irq;
    logic user;
    logic [23:0] fault_addr;
    logic [31:0] rdata;
    mag_mrsp_t mrsp;
    mag_srsp_t srsp;
    mag_crsp_t crsp;
    logic tbl_req;
    logic [23:0] tbl_addr;
    mag_seg_t [63:0] tbl;
  } mag_state_t;
endpackage : mag_pkg

// ### logic/mag_guard.sv
// Mode based memory access guard: privilege mode, segment translation, firewall and
// special function register checks, plus the register port that configures them.
// Assumes all requests come from logic on clk and that at most one memory request,
// one register check and one coprocessor request arrive per cycle.
`timescale 1ns/1ps
`include "mag_guard_cfg.svh"
module mag_guard (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [31:0] reg_rdata,
  input wire mag_pkg::mag_mreq_t mem_req,
  output mag_pkg::mag_mrsp_t mem_rsp,
  input wire mag_pkg::mag_sreq_t sfr_req,
  output mag_pkg::mag_srsp_t sfr_rsp,
  input wire mag_pkg::mag_creq_t cop_req,
  output mag_pkg::mag_crsp_t cop_rsp,
  output logic tbl_rd_req,
  output logic [23:0] tbl_rd_addr,
  input wire logic [31:0] tbl_rd_data,
  input wire logic tbl_rd_valid,
  output logic current_mode_user,
  output logic irq
);
  import mag_pkg::*;

  mag_state_t s_r;
  mag_state_t s_nxt;

  function automatic logic in_rng(input logic [23:0] a, input logic [23:0] lo,
                                  input logic [23:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction : in_rng

  // Physical partitioning per mode; the exchange window opens application RAM to firmware.
  function automatic logic phys_ok(input mag_mode_t m, input logic [23:0] pa, input mag_op_t op,
                                   input logic [23:0] xb, input logic [23:0] xs);
    logic trom;
    logic arom;
    logic fee;
    logic aee;
    logic fram;
    logic aram;
    logic xwin;
    logic [24:0] rel;
    trom = in_rng(pa, `MAG_TROM_LO, `MAG_TROM_HI);
    arom = in_rng(pa, `MAG_AROM_LO, `MAG_AROM_HI);
    fee = in_rng(pa, `MAG_FEE_LO, `MAG_FEE_HI);
    aee = in_rng(pa, `MAG_AEE_LO, `MAG_AEE_HI);
    fram = in_rng(pa, `MAG_FRAM_LO, `MAG_FRAM_HI);
    aram = in_rng(pa, `MAG_ARAM_LO, `MAG_ARAM_HI);
    rel = {1'b0, pa} - {1'b0, xb};
    xwin = aram && (rel < {1'b0, xs});
    phys_ok = 1'b0;
    unique case (m)
      mag_boot: phys_ok = (trom && op != op_write) || fee || fram;
      mag_test: phys_ok = ((trom || arom) && op != op_write) || fee || aee || fram || aram;
      mag_firmware: phys_ok = (trom && op != op_write) || fee ||
                              ((fram || aee || xwin) && op != op_exec);
      mag_system, mag_user: phys_ok = (arom && op != op_write) || aee || aram;
      default: phys_ok = 1'b0;
    endcase
  endfunction : phys_ok

  // Rights a user segment may really carry depend on the memory behind it.
  function automatic logic seg_ok(input logic [2:0] rt, input logic [23:0] pa, input mag_op_t op);
    logic r;
    logic w;
    logic x;
    r = rt[0];
    w = rt[1];
    x = rt[2];
    if (in_rng(pa, `MAG_AROM_LO, `MAG_AROM_HI)) begin
      w = 1'b0;
      x = x && r;
    end else begin
      w = r;
      x = x && r;
    end
    seg_ok = (op == op_read) ? r : (op == op_write) ? w : x;
  endfunction : seg_ok

  function automatic mag_grp_t sfr_grp(input logic [7:0] a);
    if (a <= `MAG_SFR_CPU_HI) sfr_grp = grp_cpu;
    else if (a <= `MAG_SFR_SEG_HI) sfr_grp = grp_seg;
    else if (a <= `MAG_SFR_SYS_HI) sfr_grp = grp_sys;
    else if (a <= `MAG_SFR_FWL_HI) sfr_grp = grp_fwl;
    else if (a <= `MAG_SFR_FWI_HI) sfr_grp = grp_fwi;
    else if (a <= `MAG_SFR_TEST_HI) sfr_grp = grp_test;
    else if (a >= `MAG_SFR_HW_LO) sfr_grp = grp_hw;
    else sfr_grp = grp_none;
  endfunction : sfr_grp

  // One policy for every register: by group and mode, components by explicit grant.
  function automatic logic grp_ok(input mag_mode_t m, input mag_grp_t g, input logic wr,
                                  input logic fw_bit, input logic seg_bit);
    logic priv;
    priv = (m == mag_boot) || (m == mag_test);
    grp_ok = 1'b0;
    unique case (g)
      grp_cpu: grp_ok = 1'b1;
      grp_seg, grp_sys: grp_ok = priv || (m == mag_system);
      grp_fwl: grp_ok = priv || (m == mag_firmware && !wr);
      grp_fwi: grp_ok = priv || (m == mag_firmware);
      grp_test: grp_ok = (m == mag_test);
      grp_hw: grp_ok = priv || (m == mag_system) ||
                       (m == mag_firmware && fw_bit) || (m == mag_user && seg_bit);
      grp_none: grp_ok = 1'b0;
    endcase
  endfunction : grp_ok

  function automatic mag_grp_t reg_grp(input logic [7:0] a);
    unique case (a)
      `MAG_REG_TBL_PTR, `MAG_REG_TBL_CNT, `MAG_REG_CTRL: reg_grp = grp_seg;
      `MAG_REG_FW_LO, `MAG_REG_FW_HI, `MAG_REG_XB_LO, `MAG_REG_XB_HI,
      `MAG_REG_XS_LO, `MAG_REG_XS_HI: reg_grp = grp_fwl;
      `MAG_REG_MODE, `MAG_REG_IRQ_ST, `MAG_REG_IRQ_MASK, `MAG_REG_FAULT: reg_grp = grp_sys;
      `MAG_REG_COPY_MODE: reg_grp = grp_cpu;
      default: reg_grp = grp_none;
    endcase
  endfunction : reg_grp

  always_comb begin
    logic [23:0] xb;
    logic [23:0] xs;
    mag_mode_t am;
    logic hit;
    logic [5:0] hidx;
    logic [23:0] pa;
    logic ok;
    logic [3:0] comp;
    mag_grp_t g;
    logic rok;
    logic wok;
    logic [2:0] ev;
    logic [2:0] clr;
    logic [8:0] wd_last;
    logic walk_start;
    xb = {s_r.xb_hi[7:0], s_r.xb_lo};
    xs = {s_r.xs_hi[7:0], s_r.xs_lo};
    am = mag_boot;
    hit = 1'b0;
    hidx = 6'h00;
    pa = 24'h000000;
    ok = 1'b0;
    comp = 4'h0;
    g = grp_none;
    rok = 1'b0;
    wok = 1'b0;
    ev = 3'h0;
    clr = 3'h0;
    wd_last = 9'h000;
    walk_start = 1'b0;
    s_nxt = s_r;
    s_nxt.mrsp = '0;
    s_nxt.srsp = '0;
    s_nxt.crsp = '0;
    s_nxt.rdata = `MAG_RST_WORD;
    s_nxt.tbl_req = 1'b0;

    // Memory access: the copy engine acts with the mode latched when it was configured.
    if (mem_req.valid) begin
      am = mem_req.copy ? s_r.copy_mode : s_r.mode;
      if (am == mag_user) begin
        for (int i = 63; i >= 0; i--) begin
          if (s_r.tbl[i].rights != 3'h0 &&
              mem_req.vaddr >= s_r.tbl[i].first && mem_req.vaddr <= s_r.tbl[i].last) begin
            hit = 1'b1;
            hidx = i[5:0];
          end
        end
        pa = mem_req.vaddr + s_r.tbl[hidx].reloc;
        ok = hit && seg_ok(s_r.tbl[hidx].rights, pa, mem_req.op) &&
             phys_ok(am, pa, mem_req.op, xb, xs);
      end else begin
        pa = mem_req.vaddr;
        ok = phys_ok(am, pa, mem_req.op, xb, xs);
      end
      if (mem_req.copy && mem_req.op == op_exec) begin
        ok = 1'b0;
      end
      s_nxt.mrsp.valid = 1'b1;
      s_nxt.mrsp.grant = ok;
      s_nxt.mrsp.fault = !ok;
      s_nxt.mrsp.paddr = ok ? pa : 24'h000000;
      if (ok && !mem_req.copy && mem_req.op == op_exec && am == mag_user) begin
        s_nxt.cur_seg = hidx;
      end
      if (!ok) begin
        ev[`MAG_IRQ_MEM] = 1'b1;
        s_nxt.fault_addr = mem_req.vaddr;
      end
    end

    // Register check for the processor's special function register accesses.
    if (sfr_req.valid) begin
      comp = sfr_req.addr[6:3];
      g = sfr_grp(sfr_req.addr);
      rok = grp_ok(s_r.mode, g, sfr_req.write,
                   sfr_req.write ? s_r.fw_hi[comp] : s_r.fw_lo[comp],
                   s_r.tbl[s_r.cur_seg].sfr_perm[comp]);
      s_nxt.srsp.valid = 1'b1;
      s_nxt.srsp.grant = rok;
      s_nxt.srsp.fault = !rok;
      s_nxt.srsp.user_bank = (g == grp_cpu) && (s_r.mode == mag_user);
      if (!rok) begin
        ev[`MAG_IRQ_SFR] = 1'b1;
      end
    end

    // The coprocessor bypasses translation but only ever lands in its own RAM.
    if (cop_req.valid) begin
      s_nxt.crsp.valid = 1'b1;
      s_nxt.crsp.write = cop_req.write;
      s_nxt.crsp.paddr = `MAG_COP_BASE + {11'h000, cop_req.offset};
    end

    // Register port, gated by the same policy as any other register.
    // Firmware must still be able to hand over to system mode; the advance-only
    // check below keeps that write from ever stepping back.
    wok = grp_ok(s_r.mode, reg_grp(reg_addr), 1'b1, 1'b0, 1'b0) ||
          (reg_addr == `MAG_REG_MODE && s_r.mode == mag_firmware);
    if (reg_re) begin
      if (grp_ok(s_r.mode, reg_grp(reg_addr), 1'b0, 1'b0, 1'b0)) begin
        unique case (reg_addr)
          `MAG_REG_MODE: s_nxt.rdata = {29'h0, s_r.mode};
          `MAG_REG_TBL_PTR: s_nxt.rdata = {8'h00, s_r.tbl_ptr};
          `MAG_REG_TBL_CNT: s_nxt.rdata = {25'h0, s_r.tbl_cnt};
          `MAG_REG_CTRL: s_nxt.rdata = {23'h0, s_r.cur_seg, 2'h0, s_r.walk != walk_idle};
          `MAG_REG_FW_LO: s_nxt.rdata = {16'h0000, s_r.fw_lo};
          `MAG_REG_FW_HI: s_nxt.rdata = {16'h0000, s_r.fw_hi};
          `MAG_REG_XB_LO: s_nxt.rdata = {16'h0000, s_r.xb_lo};
          `MAG_REG_XB_HI: s_nxt.rdata = {16'h0000, s_r.xb_hi};
          `MAG_REG_XS_LO: s_nxt.rdata = {16'h0000, s_r.xs_lo};
          `MAG_REG_XS_HI: s_nxt.rdata = {16'h0000, s_r.xs_hi};
          `MAG_REG_COPY_MODE: s_nxt.rdata = {29'h0, s_r.copy_mode};
          `MAG_REG_IRQ_ST: s_nxt.rdata = {29'h0, s_r.irq_st};
          `MAG_REG_IRQ_MASK: s_nxt.rdata = {29'h0, s_r.irq_mask};
          `MAG_REG_FAULT: s_nxt.rdata = {8'h00, s_r.fault_addr};
          default: s_nxt.rdata = `MAG_RST_WORD;
        endcase
      end else begin
        ev[`MAG_IRQ_SFR] = 1'b1;
      end
    end
    if (reg_we && !wok) begin
      ev[`MAG_IRQ_SFR] = 1'b1;
    end else if (reg_we) begin
      unique case (reg_addr)
        `MAG_REG_MODE: begin
          // Mode writes only advance; a write that would step back is refused as a fault.
          if (reg_wdata[2:0] >= s_r.mode && reg_wdata[2:0] <= mag_user) begin
            s_nxt.mode = mag_mode_t'(reg_wdata[2:0]);
          end else begin
            ev[`MAG_IRQ_SFR] = 1'b1;
          end
        end
        `MAG_REG_TBL_PTR: s_nxt.tbl_ptr = reg_wdata[23:0];
        `MAG_REG_TBL_CNT: s_nxt.tbl_cnt = (reg_wdata[6:0] > `MAG_SEG_MAX) ? `MAG_SEG_MAX :
                                          reg_wdata[6:0];
        `MAG_REG_CTRL: walk_start = reg_wdata[0] && (s_r.walk == walk_idle);
        `MAG_REG_FW_LO: s_nxt.fw_lo = reg_wdata[15:0];
        `MAG_REG_FW_HI: s_nxt.fw_hi = reg_wdata[15:0];
        `MAG_REG_XB_LO: s_nxt.xb_lo = reg_wdata[15:0];
        `MAG_REG_XB_HI: s_nxt.xb_hi = reg_wdata[15:0];
        `MAG_REG_XS_LO: s_nxt.xs_lo = reg_wdata[15:0];
        `MAG_REG_XS_HI: s_nxt.xs_hi = reg_wdata[15:0];
        `MAG_REG_COPY_MODE: s_nxt.copy_mode = s_r.mode;
        `MAG_REG_IRQ_ST: clr = reg_wdata[2:0];
        `MAG_REG_IRQ_MASK: s_nxt.irq_mask = reg_wdata[2:0];
        default: ;
      endcase
    end

    // A refused user memory access (copies aside) or register check hands control back to system mode for its handler.
    if (s_r.mode == mag_user && ((mem_req.valid && !mem_req.copy && !ok) ||
                                 (sfr_req.valid && !rok))) begin
      s_nxt.mode = mag_system;
    end

    // Table walker: every reload first disables all entries, so a short table leaves
    // no stale segment behind; each entry counts for user accesses once its rights word is fetched.
    wd_last = {s_r.tbl_cnt, 2'b00} - 9'h001;
    unique case (s_r.walk)
      walk_idle: begin
        if (walk_start) begin
          for (int i = 0; i < 64; i++) begin
            s_nxt.tbl[i] = '0;
          end
          s_nxt.wd = 9'h000;
          if (s_r.tbl_cnt == 7'h00) begin
            ev[`MAG_IRQ_WALK] = 1'b1;
          end else begin
            s_nxt.walk = walk_req;
          end
        end
      end
      walk_req: begin
        s_nxt.tbl_req = 1'b1;
        s_nxt.tbl_addr = s_r.tbl_ptr + {13'h0000, s_r.wd, 2'b00};
        s_nxt.walk = walk_wait;
      end
      walk_wait: begin
        if (tbl_rd_valid) begin
          unique case (s_r.wd[1:0])
            2'h0: begin
              s_nxt.tbl[s_r.wd[7:2]].rights = tbl_rd_data[2:0];
              s_nxt.tbl[s_r.wd[7:2]].sfr_perm = tbl_rd_data[31:16];
            end
            2'h1: s_nxt.tbl[s_r.wd[7:2]].first = tbl_rd_data[23:0];
            2'h2: s_nxt.tbl[s_r.wd[7:2]].last = tbl_rd_data[23:0];
            2'h3: s_nxt.tbl[s_r.wd[7:2]].reloc = tbl_rd_data[23:0];
          endcase
          s_nxt.wd = s_r.wd + 9'h001;
          if (s_r.wd == wd_last) begin
            s_nxt.walk = walk_idle;
            ev[`MAG_IRQ_WALK] = 1'b1;
          end else begin
            s_nxt.walk = walk_req;
          end
        end
      end
      default: s_nxt.walk = walk_idle;
    endcase

    s_nxt.user = (s_nxt.mode == mag_user);

    // A new event outweighs a clear written in the same cycle.
    s_nxt.irq_st = (s_r.irq_st & ~clr) | ev;
    s_nxt.irq = |(s_nxt.irq_st & s_nxt.irq_mask);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata = s_r.rdata;
  assign mem_rsp = s_r.mrsp;
  assign sfr_rsp = s_r.srsp;
  assign cop_rsp = s_r.crsp;
  assign tbl_rd_req = s_r.tbl_req;
  assign tbl_rd_addr = s_r.tbl_addr;
  assign current_mode_user = s_r.user;
  assign irq = s_r.irq;
endmodule : mag_guard

// ### testbench/mag_guard_chk.sv
// Port checker for the access guard: answer timing, verdict shape and mode entry.
// Assumes the constants header is on the include path and rst_b is active low.
`timescale 1ns/1ps
`include "mag_guard_cfg.svh"
module mag_guard_chk (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  input wire logic [31:0] reg_rdata,
  input wire mag_pkg::mag_mreq_t mem_req,
  input wire mag_pkg::mag_mrsp_t mem_rsp,
  input wire mag_pkg::mag_sreq_t sfr_req,
  input wire mag_pkg::mag_srsp_t sfr_rsp,
  input wire mag_pkg::mag_creq_t cop_req,
  input wire mag_pkg::mag_crsp_t cop_rsp,
  input wire logic tbl_rd_req,
  input wire logic [23:0] tbl_rd_addr,
  input wire logic [31:0] tbl_rd_data,
  input wire logic tbl_rd_valid,
  input wire logic current_mode_user,
  input wire logic irq
);
  import mag_pkg::*;
  logic mwr1_r;
  logic mwr2_r;
  // The user flag follows a mode write by exactly one cycle, which mwr1_r covers; mwr2_r keeps a second stage.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mwr1_r <= 1'b0;
      mwr2_r <= 1'b0;
    end else begin
      mwr1_r <= reg_we && (reg_addr == `MAG_REG_MODE);
      mwr2_r <= mwr1_r;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_mreq;
    mem_req.valid;
  endsequence
  sequence s_mrsp;
    mem_rsp.valid;
  endsequence
  sequence s_creq;
    cop_req.valid;
  endsequence
  mem_answer_a: assert property (s_mreq |=> s_mrsp)
    else $error("memory check not answered in one cycle");
  mem_quiet_a: assert property (!mem_req.valid |=> !mem_rsp.valid)
    else $error("memory answer without request");
  deny_clean_a: assert property (s_mrsp and !mem_rsp.grant |->
    mem_rsp.fault && mem_rsp.paddr == 24'h000000) else $error("denied access leaks");
  grant_region_a: assert property (s_mrsp and mem_rsp.grant |->
    mem_rsp.paddr <= `MAG_AROM_HI ||
    (mem_rsp.paddr >= `MAG_FEE_LO && mem_rsp.paddr <= `MAG_AEE_HI) ||
    (mem_rsp.paddr >= `MAG_FRAM_LO && mem_rsp.paddr <= `MAG_ARAM_HI))
    else $error("granted address outside memories");
  sfr_answer_a: assert property (sfr_rsp.valid == $past(sfr_req.valid))
    else $error("register check answer misplaced");
  sfr_verdict_a: assert property (sfr_rsp.valid |-> sfr_rsp.grant ^ sfr_rsp.fault)
    else $error("register check verdict not exclusive");
  cop_direct_a: assert property (s_creq |=> cop_rsp.valid &&
    cop_rsp.write == $past(cop_req.write) &&
    cop_rsp.paddr == `MAG_COP_BASE + {11'h000, $past(cop_req.offset)})
    else $error("coprocessor address wrong");
  user_entry_a: assert property ($rose(current_mode_user) |-> mwr1_r || mwr2_r)
    else $error("user mode entered without mode write");
  user_fault_a: assert property (s_mrsp and mem_rsp.fault && !$past(mem_req.copy) &&
    $past(current_mode_user) |-> ##[0:1] !current_mode_user) else $error("fault kept user mode");
  rdata_idle_a: assert property (!$past(reg_re) |-> reg_rdata == 32'h00000000)
    else $error("read data outside its cycle");
  tbl_pulse_a: assert property (tbl_rd_req |-> tbl_rd_addr[1:0] == 2'h0 ##1 !tbl_rd_req)
    else $error("table fetch not a word pulse");
endmodule : mag_guard_chk

// ### testbench/mag_tbl_mem.sv
// Memory holding the segment table, answering fetches two or five cycles later in turn.
// Assumes the table pointer is BASE and BASE is 64-byte aligned.
`timescale 1ns/1ps
module mag_tbl_mem #(
  parameter logic [23:0] BASE = 24'h200900
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic tbl_rd_req,
  input wire logic [23:0] tbl_rd_addr,
  output logic [31:0] tbl_rd_data,
  output logic tbl_rd_valid
);
  logic [31:0] mem [0:11];
  logic [23:0] off;
  logic [3:0] idx_r;
  logic [2:0] wait_r;
  logic busy_r;
  logic slow_r;
  assign off = tbl_rd_addr - BASE;
  // Entry 0 rx with component 0, entry 1 rw, entry 2 no rights.
  initial begin
    mem = '{32'h00010005, 32'h00000000, 32'h00000FFF, 32'h00010000,
            32'h00000003, 32'h00001000, 32'h00001FFF, 32'h001FF800,
            32'hFFFF0000, 32'h00002000, 32'h00002FFF, 32'h00110000};
  end
  // Idle data flips every cycle so a stale word is never mistaken for an answer.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_r <= 1'b0;
      slow_r <= 1'b0;
      wait_r <= 3'h0;
      idx_r <= 4'h0;
      tbl_rd_valid <= 1'b0;
      tbl_rd_data <= 32'h00000000;
    end else begin
      tbl_rd_valid <= 1'b0;
      tbl_rd_data <= ~tbl_rd_data;
      if (tbl_rd_req) begin
        busy_r <= 1'b1;
        idx_r <= off[5:2];
        wait_r <= slow_r ? 3'h3 : 3'h0;
        slow_r <= ~slow_r;
      end else if (busy_r && wait_r == 3'h0) begin
        busy_r <= 1'b0;
        tbl_rd_valid <= 1'b1;
        tbl_rd_data <= mem[idx_r];
      end else if (busy_r) begin
        wait_r <= wait_r - 3'h1;
      end
    end
  end
endmodule : mag_tbl_mem

// ### testbench/test_mode_based_memory_access_guard.sv
// Bench for the access guard: mode walk from boot to user with table load and checks.
// Assumes the constants header is on the include path.
`timescale 1ns/1ps
`include "mag_guard_cfg.svh"
module test_mode_based_memory_access_guard;
  import mag_pkg::*;
  logic clk;
  logic rst_b;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_we;
  logic reg_re;
  logic [31:0] reg_rdata;
  mag_mreq_t mem_req;
  mag_mrsp_t mem_rsp;
  mag_sreq_t sfr_req;
  mag_srsp_t sfr_rsp;
  mag_creq_t cop_req;
  mag_crsp_t cop_rsp;
  logic tbl_rd_req;
  logic [23:0] tbl_rd_addr;
  logic [31:0] tbl_rd_data;
  logic tbl_rd_valid;
  logic current_mode_user;
  logic irq;
  int err_count = 0;
  int checks = 0;
  int cyc = 0;
  mag_guard mag_guard_inst (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .mem_req(mem_req), .mem_rsp(mem_rsp), .sfr_req(sfr_req), .sfr_rsp(sfr_rsp),
    .cop_req(cop_req), .cop_rsp(cop_rsp), .tbl_rd_req(tbl_rd_req), .tbl_rd_addr(tbl_rd_addr),
    .tbl_rd_data(tbl_rd_data), .tbl_rd_valid(tbl_rd_valid),
    .current_mode_user(current_mode_user), .irq(irq));
  mag_tbl_mem mag_tbl_mem_inst (.clk(clk), .rst_b(rst_b), .tbl_rd_req(tbl_rd_req),
    .tbl_rd_addr(tbl_rd_addr), .tbl_rd_data(tbl_rd_data), .tbl_rd_valid(tbl_rd_valid));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict
  // The whole run needs a few hundred cycles; the ceiling only catches a hang.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      give_verdict();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk);
    reg_re <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d, e);
  endtask : rchk
  task automatic mreq(input logic c, input mag_op_t o, input logic [23:0] a, input logic g,
                      input logic [23:0] p);
    @(posedge clk);
    mem_req <= '{valid: 1'b1, copy: c, op: o, vaddr: a};
    @(posedge clk);
    mem_req <= '0;
    #1;
    chk({6'h00, mem_rsp.valid, mem_rsp.grant, mem_rsp.paddr}, {6'h00, 1'b1, g, p});
  endtask : mreq
  task automatic sreq(input logic w, input logic [7:0] a, input logic [2:0] e);
    @(posedge clk);
    sfr_req <= '{valid: 1'b1, write: w, addr: a};
    @(posedge clk);
    sfr_req <= '0;
    #1;
    chk({29'h0, sfr_rsp.grant, sfr_rsp.fault, sfr_rsp.user_bank}, {29'h0, e});
  endtask : sreq
  task automatic user_chk(input logic e);
    repeat (2) @(posedge clk);
    #1;
    chk({31'h0, current_mode_user}, {31'h0, e});
  endtask : user_chk
  task automatic irq_chk(input logic e);
    @(posedge clk);
    #1;
    chk({31'h0, irq}, {31'h0, e});
  endtask : irq_chk
  task automatic walk_wait;
    logic [31:0] d;
    int n;
    d = '0;
    n = 0;
    while (d[2] !== 1'b1 && n < 100) begin
      rd(`MAG_REG_IRQ_ST, d);
      n++;
    end
    chk(d & 32'h4, 32'h4);
  endtask : walk_wait
  initial begin
    rst_b = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_we = 1'b0;
    reg_re = 1'b0;
    mem_req = '0;
    sfr_req = '0;
    cop_req = '0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    rchk(`MAG_REG_MODE, 32'h0);
    rchk(`MAG_REG_FW_LO, 32'h0);
    $display("test reset done");
    sreq(1'b0, 8'h60, 3'b010);
    sreq(1'b1, 8'h40, 3'b100);
    rchk(`MAG_REG_IRQ_ST, 32'h2);
    irq_chk(1'b0);
    mreq(1'b0, op_read, 24'h000100, 1'b1, 24'h000100);
    mreq(1'b0, op_write, 24'h200900, 1'b0, 24'h0);
    rchk(`MAG_REG_FAULT, 32'h00200900);
    wr(`MAG_REG_FW_LO, 32'h1);
    wr(`MAG_REG_FW_HI, 32'h0);
    rchk(`MAG_REG_FW_LO, 32'h1);
    wr(`MAG_REG_TBL_PTR, 32'h00200900);
    wr(`MAG_REG_TBL_CNT, 32'h3);
    wr(`MAG_REG_CTRL, 32'h1);
    walk_wait();
    $display("test boot done");
    wr(`MAG_REG_MODE, 32'h2);
    wr(`MAG_REG_FW_LO, 32'hFFFF);
    rchk(`MAG_REG_FW_LO, 32'h1);
    sreq(1'b0, 8'h80, 3'b100);
    sreq(1'b1, 8'h80, 3'b010);
    sreq(1'b0, 8'h88, 3'b010);
    sreq(1'b0, 8'h50, 3'b100);
    mreq(1'b0, op_write, 24'h200100, 1'b1, 24'h200100);
    mreq(1'b0, op_read, 24'h010000, 1'b0, 24'h0);
    @(posedge clk);
    cop_req <= '{valid: 1'b1, write: 1'b1, offset: 13'h0010};
    @(posedge clk);
    cop_req <= '0;
    #1;
    chk({6'h00, cop_rsp.valid, cop_rsp.write, cop_rsp.paddr}, 32'h0320E010);
    wr(`MAG_REG_MODE, 32'h1);
    sreq(1'b0, 8'h60, 3'b010);
    $display("test firmware done");
    wr(`MAG_REG_MODE, 32'h3);
    rchk(`MAG_REG_MODE, 32'h3);
    sreq(1'b0, 8'h30, 3'b100);
    mreq(1'b0, op_read, 24'h010000, 1'b1, 24'h010000);
    mreq(1'b0, op_exec, 24'h200100, 1'b0, 24'h0);
    wr(`MAG_REG_COPY_MODE, 32'h0);
    rchk(`MAG_REG_COPY_MODE, 32'h3);
    wr(`MAG_REG_IRQ_ST, 32'h7);
    wr(`MAG_REG_IRQ_MASK, 32'h2);
    sreq(1'b0, 8'h70, 3'b010);
    irq_chk(1'b1);
    wr(`MAG_REG_IRQ_ST, 32'h2);
    irq_chk(1'b0);
    rchk(8'h3C, 32'h0);
    rchk(`MAG_REG_IRQ_ST, 32'h2);
    $display("test system done");
    wr(`MAG_REG_MODE, 32'h4);
    user_chk(1'b1);
    mreq(1'b0, op_exec, 24'h000100, 1'b1, 24'h010100);
    mreq(1'b0, op_read, 24'h000100, 1'b1, 24'h010100);
    sreq(1'b0, 8'h80, 3'b100);
    sreq(1'b0, 8'h00, 3'b101);
    mreq(1'b1, op_read, 24'h010000, 1'b1, 24'h010000);
    mreq(1'b1, op_exec, 24'h010000, 1'b0, 24'h0);
    mreq(1'b0, op_write, 24'h001000, 1'b1, 24'h200800);
    mreq(1'b0, op_write, 24'h000100, 1'b0, 24'h0);
    user_chk(1'b0);
    wr(`MAG_REG_MODE, 32'h4);
    mreq(1'b0, op_read, 24'h002000, 1'b0, 24'h0);
    wr(`MAG_REG_MODE, 32'h4);
    sreq(1'b0, 8'h88, 3'b010);
    $display("test user done");
    wr(`MAG_REG_IRQ_ST, 32'h7);
    wr(`MAG_REG_TBL_CNT, 32'h0);
    wr(`MAG_REG_CTRL, 32'h1);
    @(posedge clk);
    rchk(`MAG_REG_IRQ_ST, 32'h4);
    wr(`MAG_REG_MODE, 32'h4);
    mreq(1'b0, op_exec, 24'h000100, 1'b0, 24'h0);
    $display("test empty table done");
    give_verdict();
  end
endmodule : test_mode_based_memory_access_guard
bind mag_guard mag_guard_chk mag_guard_chk_inst (.clk(clk), .rst_b(rst_b),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
  .reg_rdata(reg_rdata), .mem_req(mem_req), .mem_rsp(mem_rsp), .sfr_req(sfr_req),
  .sfr_rsp(sfr_rsp), .cop_req(cop_req), .cop_rsp(cop_rsp), .tbl_rd_req(tbl_rd_req),
  .tbl_rd_addr(tbl_rd_addr), .tbl_rd_data(tbl_rd_data), .tbl_rd_valid(tbl_rd_valid),
  .current_mode_user(current_mode_user), .irq(irq));
